// >>> inc/bdsp_map.svh
// Purpose: Constants of the burst-of-four DDR SRAM port: widths, depths, burst timing.
// Assumes: Half-edge counts are taken relative to the command edge of the true clock.
// Notes:   Definitions only. Include this file by its bare name.
`ifndef BDSP_MAP_SVH
`define BDSP_MAP_SVH

// ---------------------------------------------------------------------------
// Geometry
// ---------------------------------------------------------------------------
`define BDSP_ADDR_W      19
`define BDSP_DATA_W      36
`define BDSP_LANES       4
`define BDSP_LANE_W      9
`define BDSP_BURST       4
`define BDSP_WADDR_W     21
`define BDSP_DEPTH       2097152
`define BDSP_SLOTS       2

// ---------------------------------------------------------------------------
// Timing in half-clock edges, counted after the command edge
// ---------------------------------------------------------------------------
`define BDSP_RD_START_DLL 4'h4
`define BDSP_RD_START_BYP 4'h1
`define BDSP_WR_FIRST     4'h1
`define BDSP_WR_LAST      4'h4
`define BDSP_CNT_SAT      4'h8

`endif

// >>> inc/bdsp_pkg.sv
// Purpose: Types shared by the burst-of-four DDR SRAM port.
// Assumes: Constants come from the map header.
// Notes:   Slot structs carry one burst each.
`include "bdsp_map.svh"

package bdsp_pkg;

    // -----------------------------------------------------------------------
    // Pin bundle, passed through the synchroniser as one vector
    // -----------------------------------------------------------------------
    typedef struct packed {
        logic                      kTrue;
        logic                      kInv;
        logic                      readSel_n;
        logic                      writeSel_n;
        logic                      dllBypass_n;
        logic [`BDSP_ADDR_W-1:0]   addr;
        logic [`BDSP_DATA_W-1:0]   wdata;
        logic [`BDSP_LANES-1:0]    mask_n;
    } bdsp_pins_t;

    // -----------------------------------------------------------------------
    // One buffered write burst
    // -----------------------------------------------------------------------
    typedef struct packed {
        logic                                         valid;
        logic [3:0]                                   cnt;
        logic [`BDSP_ADDR_W-1:0]                      addr;
        logic [`BDSP_BURST-1:0][`BDSP_DATA_W-1:0]     data;
        logic [`BDSP_BURST-1:0][`BDSP_LANES-1:0]      en;
    } bdsp_wslot_t;

    // -----------------------------------------------------------------------
    // One read burst on its way out
    // -----------------------------------------------------------------------
    typedef struct packed {
        logic                                         active;
        logic [3:0]                                   cnt;
        logic [`BDSP_BURST-1:0][`BDSP_DATA_W-1:0]     data;
    } bdsp_rslot_t;

endpackage

// >>> rtl/bdsp_sync.sv
// Purpose: Two-stage synchroniser for the pin bundle.
// Assumes: Inputs are asynchronous to clk_sys.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/100ps

module bdsp_sync #(
    parameter int W = 8
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] sync_reg;
    logic [W-1:0] sync_next;

    // Shift one stage per clock
    always_comb begin
        meta_next = din;
        sync_next = meta_reg;
    end

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign dout = sync_reg;

endmodule

// >>> rtl/bdsp_port.sv
// Purpose: Read and write port of a burst-of-four DDR SRAM with late-write buffers.
// Assumes: clk_sys (200 MHz) oversamples both input clocks and every pin.
// Notes:   All pins pass a two-stage synchroniser, so all edges shift together.
`timescale 1ns/100ps
`include "bdsp_map.svh"

module bdsp_port (
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    input  wire logic                       clkTrue,
    input  wire logic                       clkInv,
    input  wire logic                       readSel_n,
    input  wire logic                       writeSel_n,
    input  wire logic                       dllBypass_n,
    input  wire logic [`BDSP_ADDR_W-1:0]    word_address_in,
    input  wire logic [`BDSP_DATA_W-1:0]    write_input_bus,
    input  wire logic [`BDSP_LANES-1:0]     byte_write_mask_n,
    output logic      [`BDSP_DATA_W-1:0]    read_output_bus,
    output logic                            echo_timing_true,
    output logic                            echo_timing_inv,
    output logic                            output_valid
);

    import bdsp_pkg::*;

    // -----------------------------------------------------------------------
    // Pin synchronisation and edge detection
    // -----------------------------------------------------------------------
    bdsp_pins_t               pinsRaw;
    bdsp_pins_t               pinsS;
    logic                     kPrev_reg;
    logic                     kPrev_next;
    logic                     kbPrev_reg;
    logic                     kbPrev_next;
    logic                     kRise;
    logic                     kbRise;
    logic                     halfEv;
    logic                     rdCmd;
    logic                     wrCmd;
    logic [3:0]               rdStart;

    // Bundle the pins so they all see the same synchroniser delay
    always_comb begin
        pinsRaw.kTrue       = clkTrue;
        pinsRaw.kInv        = clkInv;
        pinsRaw.readSel_n   = readSel_n;
        pinsRaw.writeSel_n  = writeSel_n;
        pinsRaw.dllBypass_n = dllBypass_n;
        pinsRaw.addr        = word_address_in;
        pinsRaw.wdata       = write_input_bus;
        pinsRaw.mask_n      = byte_write_mask_n;
    end

    bdsp_sync #(
        .W ($bits(bdsp_pins_t))
    ) uSync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .din     (pinsRaw),
        .dout    (pinsS)
    );

    // Previous clock levels for edge finding
    always_comb begin
        kPrev_next  = pinsS.kTrue;
        kbPrev_next = pinsS.kInv;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            kPrev_reg  <= 1'b0;
            kbPrev_reg <= 1'b0;
        end else begin
            kPrev_reg  <= kPrev_next;
            kbPrev_reg <= kbPrev_next;
        end
    end

    // address only used with a select
    always_comb begin
        kRise   = pinsS.kTrue & ~kPrev_reg;
        kbRise  = pinsS.kInv & ~kbPrev_reg;
        halfEv  = kRise | kbRise;
        rdCmd   = kRise & ~pinsS.readSel_n;
        wrCmd   = kRise & ~pinsS.writeSel_n;
        rdStart = pinsS.dllBypass_n ? `BDSP_RD_START_DLL : `BDSP_RD_START_BYP;
    end

    // -----------------------------------------------------------------------
    // Storage array and coherent fetch
    // -----------------------------------------------------------------------
    logic [`BDSP_DATA_W-1:0]  mem [`BDSP_DEPTH];
    logic [`BDSP_DATA_W-1:0]  fetch [`BDSP_BURST];
    bdsp_wslot_t              ws_reg [`BDSP_SLOTS];
    bdsp_wslot_t              ws_next [`BDSP_SLOTS];
    logic                     coherHit;

    // newest buffer overlays older buffer, which overlays the array
    // word i of a burst sits at the start address plus i
    for (genvar gw = 0; gw < `BDSP_BURST; gw++) begin : gFetch
        always_comb begin
            logic [`BDSP_DATA_W-1:0] w;
            w = mem[{pinsS.addr, 2'(gw)}];
            for (int s = 0; s < `BDSP_SLOTS; s++) begin
                if (ws_reg[s].valid && ws_reg[s].addr == pinsS.addr) begin
                    for (int b = 0; b < `BDSP_LANES; b++) begin
                        if (ws_reg[s].en[gw][b]) begin
                            w[b*`BDSP_LANE_W +: `BDSP_LANE_W] =
                                ws_reg[s].data[gw][b*`BDSP_LANE_W +: `BDSP_LANE_W];
                        end
                    end
                end
            end
            fetch[gw] = w;
        end
    end

    // Used only by coverage of the buffer bypass path
    assign coherHit = rdCmd && ((ws_reg[0].valid && ws_reg[0].addr == pinsS.addr) ||
                                (ws_reg[1].valid && ws_reg[1].addr == pinsS.addr));

    // commit the oldest buffer when a new write arrives
    // only enabled lanes of each word reach the array
    always_ff @(posedge clk_sys) begin
        if (!rst && wrCmd && ws_reg[0].valid) begin
            for (int i = 0; i < `BDSP_BURST; i++) begin
                for (int b = 0; b < `BDSP_LANES; b++) begin
                    if (ws_reg[0].en[i][b]) begin
                        mem[{ws_reg[0].addr, 2'(i)}][b*`BDSP_LANE_W +: `BDSP_LANE_W] <=
                            ws_reg[0].data[i][b*`BDSP_LANE_W +: `BDSP_LANE_W];
                    end
                end
            end
        end
    end

    // -----------------------------------------------------------------------
    // Write buffers
    // -----------------------------------------------------------------------
    // words and masks captured together on half edges 2 to 5
    // no slot allocated or shifted without a write command
    always_comb begin
        logic [3:0] off;
        off = 4'h0;
        for (int s = 0; s < `BDSP_SLOTS; s++) begin
            ws_next[s] = ws_reg[s];
        end
        if (halfEv) begin
            for (int s = 0; s < `BDSP_SLOTS; s++) begin
                if (ws_reg[s].valid) begin
                    if (ws_reg[s].cnt >= `BDSP_WR_FIRST && ws_reg[s].cnt <= `BDSP_WR_LAST) begin
                        off = ws_reg[s].cnt - `BDSP_WR_FIRST;
                        ws_next[s].data[off[1:0]] = pinsS.wdata;
                        ws_next[s].en[off[1:0]]   = ~pinsS.mask_n;
                    end
                    if (ws_reg[s].cnt != `BDSP_CNT_SAT) begin
                        ws_next[s].cnt = ws_reg[s].cnt + 4'h1;
                    end
                end
            end
        end
        // new burst takes the newest slot, older one shifts down
        if (wrCmd) begin
            ws_next[0]       = ws_next[1];
            ws_next[1]       = '0;
            ws_next[1].valid = 1'b1;
            ws_next[1].addr  = pinsS.addr;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int s = 0; s < `BDSP_SLOTS; s++) begin
                ws_reg[s] <= '0;
            end
        end else begin
            ws_reg <= ws_next;
        end
    end

    // -----------------------------------------------------------------------
    // Read bursts and output pins
    // -----------------------------------------------------------------------
    bdsp_rslot_t              rs_reg [`BDSP_SLOTS];
    bdsp_rslot_t              rs_next [`BDSP_SLOTS];
    logic                     rdSel_reg;
    logic                     rdSel_next;
    logic [`BDSP_DATA_W-1:0]  rdData_reg;
    logic [`BDSP_DATA_W-1:0]  rdData_next;
    logic                     valid_reg;
    logic                     valid_next;
    logic                     echoT_reg;
    logic                     echoT_next;
    logic                     echoI_reg;
    logic                     echoI_next;

    // reads run on their own slots, never waiting on writes
    // Two slots cover the overlap of back-to-back bursts
    always_comb begin
        logic [3:0] off;
        off         = 4'h0;
        rdSel_next  = rdSel_reg;
        rdData_next = rdData_reg;
        valid_next  = valid_reg;
        for (int s = 0; s < `BDSP_SLOTS; s++) begin
            rs_next[s] = rs_reg[s];
        end
        if (halfEv) begin
            valid_next = 1'b0;
            for (int s = 0; s < `BDSP_SLOTS; s++) begin
                if (rs_reg[s].active) begin
                    // one word per half edge from the start count
                    if (rs_reg[s].cnt >= rdStart && rs_reg[s].cnt <= rdStart + 4'h3) begin
                        off         = rs_reg[s].cnt - rdStart;
                        rdData_next = rs_reg[s].data[off[1:0]];
                    end
                    // valid spans one half edge early through the second word
                    if (rs_reg[s].cnt + 4'h1 >= rdStart && rs_reg[s].cnt <= rdStart + 4'h1) begin
                        valid_next = 1'b1;
                    end
                    // burst ends only after its fourth word
                    if (rs_reg[s].cnt >= rdStart + 4'h3) begin
                        rs_next[s].active = 1'b0;
                    end else begin
                        rs_next[s].cnt = rs_reg[s].cnt + 4'h1;
                    end
                end
            end
        end
        // read captures address and data on the command edge
        if (rdCmd) begin
            rs_next[rdSel_reg].active = 1'b1;
            rs_next[rdSel_reg].cnt    = 4'h0;
            for (int i = 0; i < `BDSP_BURST; i++) begin
                rs_next[rdSel_reg].data[i] = fetch[i];
            end
            rdSel_next = ~rdSel_reg;
        end
        // echo clocks follow the same sampled clocks as the data
        echoT_next = pinsS.kTrue;
        echoI_next = pinsS.kInv;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int s = 0; s < `BDSP_SLOTS; s++) begin
                rs_reg[s] <= '0;
            end
            rdSel_reg  <= 1'b0;
            rdData_reg <= '0;
            valid_reg  <= 1'b0;
            echoT_reg  <= 1'b0;
            echoI_reg  <= 1'b0;
        end else begin
            rs_reg     <= rs_next;
            rdSel_reg  <= rdSel_next;
            rdData_reg <= rdData_next;
            valid_reg  <= valid_next;
            echoT_reg  <= echoT_next;
            echoI_reg  <= echoI_next;
        end
    end

    assign read_output_bus  = rdData_reg;
    assign echo_timing_true = echoT_reg;
    assign echo_timing_inv  = echoI_reg;
    assign output_valid     = valid_reg;

    // -----------------------------------------------------------------------
    // Assertions and coverage
    // -----------------------------------------------------------------------
    default clocking cbSys @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_mask_blocks_lane: assert property (
        (halfEv && !wrCmd && ws_reg[1].valid && ws_reg[1].cnt == 4'h1 && pinsS.mask_n[0])
        |=> !ws_reg[1].en[0][0])
        else $error("masked lane was enabled");

    chk_mask_with_data: assert property (
        (halfEv && !wrCmd && ws_reg[1].valid && ws_reg[1].cnt == 4'h2)
        |=> ws_reg[1].data[1] == $past(pinsS.wdata) && ws_reg[1].en[1] == ~$past(pinsS.mask_n))
        else $error("mask and data not taken on the same edge");

    chk_burst_of_four: assert property (
        $fell(rs_reg[0].active) |-> $past(rs_reg[0].cnt) == $past(rdStart) + 4'h3)
        else $error("read burst ended after wrong word count");

    chk_first_word_out: assert property (
        (halfEv && rs_reg[0].active && rs_reg[0].cnt == rdStart)
        |=> read_output_bus == $past(rs_reg[0].data[0]))
        else $error("first read word not driven at start count");

    chk_echo_tracks_clk: assert property (
        kRise |=> echo_timing_true ##1 $stable(echo_timing_true) || !pinsS.kTrue)
        else $error("echo clock does not follow input clock");

    chk_nop_keeps_read: assert property (
        (rs_reg[0].active && rs_reg[0].cnt < rdStart && pinsS.readSel_n)
        |=> rs_reg[0].active)
        else $error("idle read select cut a burst short");

    chk_write_alloc: assert property (
        wrCmd |=> ws_reg[1].valid && ws_reg[1].addr == $past(pinsS.addr) && ws_reg[1].cnt == 4'h0)
        else $error("write command not captured");

    chk_idle_no_write: assert property (
        (kRise && pinsS.writeSel_n) |=> ws_reg[1].addr == $past(ws_reg[1].addr))
        else $error("write slot changed without command");

    chk_valid_leads: assert property (
        (halfEv && rs_reg[0].active && rs_reg[0].cnt + 4'h1 == rdStart) |=> output_valid)
        else $error("output valid did not lead first word");

    cov_read_cmd:   cover property (rdCmd);
    cov_write_cmd:  cover property (wrCmd);
    cov_concurrent: cover property (rdCmd && wrCmd);
    cov_coherent:   cover property (coherHit);

endmodule

// >>> dv/bdsp_ctrl_model.sv
// Purpose: Memory controller model driving the port's clock pair, selects and write data.
// Assumes: Pins change 12 ns after each half edge, mid-way between a rise and a fall.
// Notes:   Clock pair runs free at 48 ns; idle data and mask lines toggle every half.
`timescale 1ns/100ps
`include "bdsp_map.svh"

module bdsp_ctrl_model (
    output logic                    clkTrue,
    output logic                    clkInv,
    output logic                    readSel_n,
    output logic                    writeSel_n,
    output logic [`BDSP_ADDR_W-1:0] word_address_in,
    output logic [`BDSP_DATA_W-1:0] write_input_bus,
    output logic [`BDSP_LANES-1:0]  byte_write_mask_n,
    output int                      halfIdx
);
    logic [`BDSP_DATA_W-1:0] dataQ [int];
    logic [`BDSP_LANES-1:0]  maskQ [int];

    // ------------------------------------------------------------------
    // Clock pair and pin defaults
    // ------------------------------------------------------------------
    // Odd half edges are true rises; the offset keeps them off clk_sys edges
    initial begin
        clkTrue           = 1'b0;
        clkInv            = 1'b1;
        halfIdx           = 0;
        readSel_n         = 1'b1;
        writeSel_n        = 1'b1;
        word_address_in   = '0;
        write_input_bus   = '0;
        byte_write_mask_n = '1;
        #1.3;
        forever begin
            #24;
            clkTrue = ~clkTrue;
            clkInv  = ~clkInv;
            halfIdx = halfIdx + 1;
        end
    end

    // ------------------------------------------------------------------
    // Write data lane
    // ------------------------------------------------------------------
    // word with its mask
    always @(halfIdx) begin
        #12;
        if (dataQ.exists(halfIdx + 1)) begin
            write_input_bus   = dataQ[halfIdx + 1];
            byte_write_mask_n = maskQ[halfIdx + 1];
        end else begin
            // Released lines must not keep showing the last word
            write_input_bus   = ~write_input_bus;
            byte_write_mask_n = ~byte_write_mask_n;
        end
    end

    // command on a true rise; caller keeps each port two cycles apart
    task automatic cmd(input logic rd, input logic wr, input logic [`BDSP_ADDR_W-1:0] a,
                       input logic [3:0][`BDSP_DATA_W-1:0] wd, input logic [3:0][3:0] wm,
                       output int c);
        @(halfIdx);
        while (halfIdx[0] !== 1'b0) @(halfIdx);
        #12;
        c               = halfIdx + 1;
        readSel_n       = ~rd;
        writeSel_n      = ~wr;
        word_address_in = a;
        for (int k = 0; k < 4; k++) begin
            if (wr) begin
                dataQ[c + 2 + k] = wd[k];
                maskQ[c + 2 + k] = wm[k];
            end
        end
        @(halfIdx);
        #12;
        readSel_n       = 1'b1;
        writeSel_n      = 1'b1;
        word_address_in = ~a;
    endtask
endmodule

// >>> dv/bdsp_port_test.sv
// Purpose: Self-checking bench of the burst-of-four DDR SRAM port.
// Assumes: Controller model drives the link pins; bench drives rst and dllBypass_n.
// Notes:   Outputs are captured 22 ns after each half edge, where they are settled.
`timescale 1ns/100ps
`include "bdsp_map.svh"

module bdsp_port_test;
    import bdsp_pkg::*;
    logic                     clk_sys;
    logic                     rst;
    logic                     dllBypass_n;
    logic                     clkTrue;
    logic                     clkInv;
    logic                     readSel_n;
    logic                     writeSel_n;
    logic [`BDSP_ADDR_W-1:0]  addr;
    logic [`BDSP_DATA_W-1:0]  wdata;
    logic [`BDSP_LANES-1:0]   mask_n;
    logic [`BDSP_DATA_W-1:0]  rdata;
    logic                     echoTrue;
    logic                     echoInv;
    logic                     outValid;
    int                       halfIdx;
    int                       hCap;
    int                       n_fail;
    int                       tests_run;
    int                       cycles;
    logic [`BDSP_DATA_W-1:0]  qd [int];
    logic                     qv [int];
    logic [1:0]               qe [int];
    logic [`BDSP_DATA_W-1:0]  mem [logic [20:0]];

    bdsp_ctrl_model i_ctrl (.clkTrue(clkTrue), .clkInv(clkInv), .readSel_n(readSel_n),
        .writeSel_n(writeSel_n), .word_address_in(addr), .write_input_bus(wdata),
        .byte_write_mask_n(mask_n), .halfIdx(halfIdx));

    bdsp_port i_dut (.clk_sys(clk_sys), .rst(rst), .clkTrue(clkTrue), .clkInv(clkInv),
        .readSel_n(readSel_n), .writeSel_n(writeSel_n), .dllBypass_n(dllBypass_n),
        .word_address_in(addr), .write_input_bus(wdata), .byte_write_mask_n(mask_n),
        .read_output_bus(rdata), .echo_timing_true(echoTrue), .echo_timing_inv(echoInv),
        .output_valid(outValid));

    // ------------------------------------------------------------------
    // Clock, capture and hang guard
    // ------------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // One snapshot per half edge, before the next edge can reach the outputs
    always begin
        @(halfIdx);
        hCap = halfIdx;
        #22;
        qd[hCap] = rdata;
        qv[hCap] = outValid;
        qe[hCap] = {echoTrue, echoInv};
    end

    // Whole run needs about 900 cycles; over twenty times that means a hang
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            final_report();
        end
    end

    // ------------------------------------------------------------------
    // Compare, report and transfer helpers
    // ------------------------------------------------------------------
    task automatic cmp_word(input logic [`BDSP_DATA_W-1:0] got,
                            input logic [`BDSP_DATA_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    function automatic logic [3:0][35:0] mk(input logic [7:0] s);
        for (int k = 0; k < 4; k++) mk[k] = {s, 8'(k), ~s, 8'(k), 4'h5};
    endfunction

    task automatic idle(input int halves);
        repeat (halves) @(halfIdx);
    endtask

    // Expected contents follow every byte that a low mask lets through
    task automatic wr_burst(input logic [18:0] a, input logic [3:0][35:0] wd,
                            input logic [3:0][3:0] wm);
        int c;
        i_ctrl.cmd(1'b0, 1'b1, a, wd, wm, c);
        for (int k = 0; k < 4; k++) begin
            for (int b = 0; b < 4; b++) begin
                if (!wm[k][b]) mem[{a, 2'(k)}][9*b +: 9] = wd[k][9*b +: 9];
            end
        end
    endtask

    task automatic rd_issue(input logic [18:0] a, output int c, output logic [3:0][35:0] e);
        i_ctrl.cmd(1'b1, 1'b0, a, '0, '1, c);
        for (int k = 0; k < 4; k++) e[k] = mem[{a, 2'(k)}];
    endtask

    task automatic rd_check(input int c, input int h0, input logic [3:0][35:0] e);
        int n;
        n = 0;
        while (!qd.exists(c + h0 + 3) && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        for (int k = 0; k < 4; k++) cmp_word(qd[c + h0 + k], e[k]);
        cmp_bit(qv[c + h0 - 2], 1'b0);
        cmp_bit(qv[c + h0 - 1], 1'b1);
        cmp_bit(qv[c + h0 + 1], 1'b1);
        cmp_bit(qv[c + h0 + 2], 1'b0);
    endtask

    task automatic rd_burst(input logic [18:0] a, input int h0);
        int                c;
        logic [3:0][35:0]  e;
        rd_issue(a, c, e);
        rd_check(c, h0, e);
        idle(4);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic s_echo();
        // Snapshots of these half edges are still to come when the task starts
        while (!qe.exists(9)) @(posedge clk_sys);
        for (int h = 6; h < 10; h++) cmp_word(36'(qe[h]), {34'h0, h[0], ~h[0]});
    endtask

    // Read straight after a write is served from the buffer
    task automatic s_buffer_read();
        wr_burst(19'h00010, mk(8'ha1), '0);
        idle(4);
        rd_burst(19'h00010, 5);
    endtask

    // Every word gets its own lane mix, from all lanes to none
    task automatic s_masks();
        wr_burst(19'h00010, mk(8'hb2), {4'hf, 4'h5, 4'ha, 4'h0});
        idle(4);
        rd_burst(19'h00010, 5);
    endtask

    // Two newer writes push the older bursts into the array
    task automatic s_commit();
        wr_burst(19'h7fffc, mk(8'hc3), '0);
        idle(2);
        wr_burst(19'h00020, mk(8'hd4), '0);
        idle(12);
        rd_burst(19'h00010, 5);
        rd_burst(19'h7fffc, 5);
        rd_burst(19'h00020, 5);
    endtask

    // Reads two cycles apart; idle select in between must not stop the first
    task automatic s_btb_read();
        int                ca;
        int                cb;
        logic [3:0][35:0]  ea;
        logic [3:0][35:0]  eb;
        rd_issue(19'h00010, ca, ea);
        idle(2);
        rd_issue(19'h00020, cb, eb);
        rd_check(ca, 5, ea);
        rd_check(cb, 5, eb);
        cmp_bit(qv[ca + 8], 1'b1);
    endtask

    // Write in the cycle right after a read, both ports busy together
    task automatic s_concurrent();
        int                c;
        logic [3:0][35:0]  e;
        rd_issue(19'h7fffc, c, e);
        wr_burst(19'h00030, mk(8'he5), {4'h0, 4'h3, 4'hc, 4'h0});
        rd_check(c, 5, e);
        idle(4);
        rd_burst(19'h00030, 5);
    endtask

    // Read and write on one edge: the read sees the data from before the write
    task automatic s_same_edge();
        int                c;
        logic [3:0][35:0]  e;
        logic [3:0][35:0]  d;
        d = mk(8'hf6);
        for (int k = 0; k < 4; k++) e[k] = mem[{19'h00030, 2'(k)}];
        i_ctrl.cmd(1'b1, 1'b1, 19'h00030, d, '0, c);
        for (int k = 0; k < 4; k++) mem[{19'h00030, 2'(k)}] = d[k];
        rd_check(c, 5, e);
        rd_burst(19'h00030, 5);
    endtask

    task automatic s_bypass();
        @(negedge clk_sys);
        dllBypass_n = 1'b0;
        idle(4);
        rd_burst(19'h00020, 2);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst         = 1'b1;
        dllBypass_n = 1'b1;
        n_fail      = 0;
        tests_run   = 0;
        repeat (5) @(negedge clk_sys);
        // All outputs are held low in reset
        cmp_word(rdata, '0);
        cmp_word({34'h0, echoTrue, echoInv}, '0);
        cmp_bit(outValid, 1'b0);
        rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        idle(4);
        s_echo();
        s_buffer_read();
        s_masks();
        s_commit();
        s_btb_read();
        s_concurrent();
        s_same_edge();
        s_bypass();
        final_report();
    end
endmodule
